// [ssp_pkg.sv]
// Purpose: Shared constants and types for the sensor serial port link.
// Assumes: 16-bit words, one write flag, seven address bits, one data byte.
// Notes: Both link ends take every figure from here; the bench takes only some.
package ssp_pkg;

  // Word layout on the serial lines
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int WR_FLAG_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam int NUM_BYTES = 128;

  // Bit counter within one word
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 4'hf;

  // Reset and idle values
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

  // Timing: system clock and ceiling on the serial bit rate
  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_BIT_RATE_BPS = 2_500_000;
  localparam int SCLK_DIV_INT =
    (CLK_HZ + MAX_BIT_RATE_BPS - 1) / MAX_BIT_RATE_BPS;
  localparam int SCLK_HALF_INT = (SCLK_DIV_INT + 1) / 2;
  localparam int PH_W = 3;
  localparam logic [PH_W-1:0] PH_ZERO = 3'h0;
  localparam logic [PH_W-1:0] PH_ONE = 3'h1;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(SCLK_HALF_INT - 1);

  // Sequencer states of the master end
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_SHIFT,
    ST_GAP,
    ST_TAIL
  } ssp_host_state_t;

  // Even byte address of the word that holds a byte
  function automatic logic [ADDR_W-1:0] ssp_lo_addr(
    input logic [ADDR_W-1:0] a
  );
    return {a[ADDR_W-1:1], 1'b0};
  endfunction : ssp_lo_addr

  // Odd byte address of the word that holds a byte
  function automatic logic [ADDR_W-1:0] ssp_hi_addr(
    input logic [ADDR_W-1:0] a
  );
    return {a[ADDR_W-1:1], 1'b1};
  endfunction : ssp_hi_addr

endpackage : ssp_pkg

// [ssp_link_if.sv]
// Purpose: The four serial lines between master end and sensor end.
// Assumes: Master makes clock and select; sensor only drives its output.
// Notes: No clocking block; both ends are design code.
`timescale 1ns/1ps
interface ssp_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;

  // Sensor end: listens to clock, select and data in
  modport dev (
    input sclk,
    input cs_n,
    input din,
    output dout
  );

  // Master end: drives clock, select and data in
  modport host (
    output sclk,
    output cs_n,
    output din,
    input dout
  );
endinterface : ssp_link_if

// [ssp_dev_end.sv]
// Purpose: Sensor end of the serial port, a pure slave on the link.
// Assumes: Link clock idles low and stops outside frames.
// Notes: Register bytes live in the system clock domain.
// Behaviour
// - Slave only; never drives clock or select.
// - Master keeps bit rate at most 2.5 Mbps.
// - Outgoing word is 16 bits, MSB first.
// - First byte flag and address, second data.
// - Sixteen clock periods make one word.
// - Select low frames back to back words.
// - Input bit taken on rising clock edge.
// - Output updated on rising edge, full duplex.
// - Read data returns in the next word.
`timescale 1ns/1ps
module ssp_dev_end (
  input wire logic clk,
  input wire logic reset_n,
  ssp_link_if.dev link,
  input wire logic usr_wr_en,
  input wire logic [ssp_pkg::ADDR_W-1:0] usr_addr,
  input wire logic [ssp_pkg::WORD_W-1:0] usr_wdata,
  output logic wr_evt,
  output logic [ssp_pkg::ADDR_W-1:0] wr_evt_addr,
  output logic [ssp_pkg::BYTE_W-1:0] wr_evt_data,
  output logic rd_evt,
  output logic [ssp_pkg::ADDR_W-1:0] rd_evt_addr,
  output logic frame_act
);
  import ssp_pkg::*;

  // ---------------- Link clock domain ----------------

  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [WORD_W-1:0] rx_sh_reg;
  logic [WORD_W-1:0] rx_word_reg;
  logic rx_tgl_reg;
  logic [WORD_W-1:0] tx_sh_reg;
  logic dout_reg;

  // ---------------- System clock domain ----------------

  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic word_evt;
  logic word_is_wr;
  logic [ADDR_W-1:0] word_addr;
  logic [BYTE_W-1:0] word_data;
  logic [WORD_W-1:0] tx_word_reg;
  logic [BYTE_W-1:0] mem [NUM_BYTES];

  // Bit position in the current word; select high clears it at once.
  // A word cut short never reaches the last bit, so it is simply lost.
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_reg <= BIT_CNT_ZERO;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
    end
  end

  // Receive shifter, one bit per rising edge, MSB arrives first
  always_ff @(posedge link.sclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sh_reg <= WORD_ZERO;
    end else begin
      rx_sh_reg <= {rx_sh_reg[WORD_W-2:0], link.din};
    end
  end

  // Whole word handed over only on the sixteenth edge.
  // The word then holds for a full word time, so it is quasi-static
  // when the system side reads it after the toggle is synchronised.
  always_ff @(posedge link.sclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_word_reg <= WORD_ZERO;
      rx_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == BIT_CNT_LAST) begin
      rx_word_reg <= {rx_sh_reg[WORD_W-2:0], link.din};
      rx_tgl_reg <= ~rx_tgl_reg;
    end
  end

  // Reply word is sampled once per word, at its first edge.
  // Transmit shifter: first edge of a word loads the reply word,
  // later edges shift; both launch a bit while input is sampled.
  always_ff @(posedge link.sclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh_reg <= WORD_ZERO;
      dout_reg <= 1'b0;
    end else if (bit_cnt_reg == BIT_CNT_ZERO) begin
      dout_reg <= tx_word_reg[WORD_W-1];
      tx_sh_reg <= {tx_word_reg[WORD_W-2:0], 1'b0};
    end else begin
      dout_reg <= tx_sh_reg[WORD_W-1];
      tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
    end
  end

  // Only the data line is driven; clock and select are inputs here
  assign link.dout = dout_reg;

  // ---------------- Crossing into system clock ----------------

  // A lone toggle, not the word, crosses: one bit cannot be torn
  // Word toggle through two flops, third flop for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= rx_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // Two flops because select moves with no regard to clk
  // Select level for the frame status output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
    end else begin
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
    end
  end

  // Decode of a finished word
  assign word_evt = tgl_s2_reg ^ tgl_s3_reg;
  assign word_is_wr = rx_word_reg[WR_FLAG_BIT];
  assign word_addr = rx_word_reg[ADDR_MSB:ADDR_LSB];
  assign word_data = rx_word_reg[DATA_MSB:DATA_LSB];

  // Register bytes. The local side updates whole words (sensor data);
  // a link write stores one byte and is applied last, so it wins a
  // same-cycle clash on that byte.
  // No reset on the bytes: contents are undefined until written,
  // so local logic must preload anything a master may read.
  always_ff @(posedge clk) begin
    if (usr_wr_en) begin
      mem[ssp_lo_addr(usr_addr)] <= usr_wdata[BYTE_W-1:0];
      mem[ssp_hi_addr(usr_addr)] <= usr_wdata[WORD_W-1:BYTE_W];
    end
    if (word_evt && word_is_wr) begin
      mem[word_addr] <= word_data;
    end
  end

  // Reply word for the next frame word: read data, else zero.
  // Limitation: the link must leave at least one bit time between the
  // last edge of a word and the first of the next for this to settle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_word_reg <= WORD_ZERO;
    end else if (word_evt) begin
      if (word_is_wr) begin
        tx_word_reg <= WORD_ZERO;
      end else begin
        tx_word_reg <= {mem[ssp_hi_addr(word_addr)],
                        mem[ssp_lo_addr(word_addr)]};
      end
    end
  end

  // Write notice to local logic, one clock per accepted write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_evt <= 1'b0;
      wr_evt_addr <= ADDR_ZERO;
      wr_evt_data <= BYTE_ZERO;
    end else begin
      wr_evt <= word_evt && word_is_wr;
      if (word_evt && word_is_wr) begin
        wr_evt_addr <= word_addr;
        wr_evt_data <= word_data;
      end
    end
  end

  // Read notice, useful to clear sticky status on read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_evt <= 1'b0;
      rd_evt_addr <= ADDR_ZERO;
    end else begin
      rd_evt <= word_evt && !word_is_wr;
      if (word_evt && !word_is_wr) begin
        rd_evt_addr <= word_addr;
      end
    end
  end

  // Lags select by three clks; status only, not a timing reference
  // Frame status, high while select is held low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_act <= 1'b0;
    end else begin
      frame_act <= ~cs_s2_reg;
    end
  end

endmodule : ssp_dev_end

// [ssp_host_end.sv]
// Purpose: Master end of the sensor serial port.
// Assumes: System clock at 20 MHz; link clock made by division.
// Notes: Data in changes on falling edges; data out sampled there too.
`timescale 1ns/1ps
module ssp_host_end (
  input wire logic clk,
  input wire logic reset_n,
  ssp_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [ssp_pkg::WORD_W-1:0] cmd_word,
  input wire logic cmd_last,
  output logic rsp_valid,
  output logic [ssp_pkg::WORD_W-1:0] rsp_word
);
  import ssp_pkg::*;

  ssp_host_state_t state_reg;
  logic [PH_W-1:0] ph_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic din_reg;
  logic last_reg;
  logic [WORD_W-1:0] tx_sh_reg;
  logic [WORD_W-1:0] rx_sh_reg;
  logic dout_s1_reg;
  logic dout_s2_reg;
  logic take;

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.din = din_reg;
  assign take = cmd_valid && cmd_ready;

  // Data out comes from the far side, two flops before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_s1_reg <= 1'b0;
      dout_s2_reg <= 1'b0;
    end else begin
      dout_s1_reg <= link.dout;
      dout_s2_reg <= dout_s1_reg;
    end
  end

  // Frame sequencer; half period fixed so the bit rate stays in bound
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      ph_reg <= PH_ZERO;
      bit_cnt_reg <= BIT_CNT_ZERO;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      din_reg <= 1'b0;
      last_reg <= 1'b0;
      tx_sh_reg <= WORD_ZERO;
      rx_sh_reg <= WORD_ZERO;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_word <= WORD_ZERO;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        ST_IDLE, ST_GAP: begin
          cmd_ready <= 1'b1;
          if (take) begin
            cmd_ready <= 1'b0;
            cs_n_reg <= 1'b0;
            din_reg <= cmd_word[WORD_W-1];
            tx_sh_reg <= {cmd_word[WORD_W-2:0], 1'b0};
            last_reg <= cmd_last;
            ph_reg <= PH_ZERO;
            bit_cnt_reg <= BIT_CNT_ZERO;
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          // Data in settles a full period before the first rise
          if (ph_reg == PH_LAST) begin
            ph_reg <= PH_ZERO;
            state_reg <= ST_SHIFT;
          end else begin
            ph_reg <= ph_reg + PH_ONE;
          end
        end
        ST_SHIFT: begin
          if (ph_reg == PH_LAST) begin
            ph_reg <= PH_ZERO;
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              rx_sh_reg <= {rx_sh_reg[WORD_W-2:0], dout_s2_reg};
              bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
              if (bit_cnt_reg == BIT_CNT_LAST) begin
                // Sixteen full periods always given
                rsp_valid <= 1'b1;
                rsp_word <= {rx_sh_reg[WORD_W-2:0], dout_s2_reg};
                state_reg <= last_reg ? ST_TAIL : ST_GAP;
              end else begin
                din_reg <= tx_sh_reg[WORD_W-1];
                tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
              end
            end
          end else begin
            ph_reg <= ph_reg + PH_ONE;
          end
        end
        ST_TAIL: begin
          // Hold select a half period past the last fall
          if (ph_reg == PH_LAST) begin
            ph_reg <= PH_ZERO;
            cs_n_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            ph_reg <= ph_reg + PH_ONE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cs_n_reg <= 1'b1;
          sclk_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule : ssp_host_end

// [ssp_link_props.sv]
// Purpose: Timing checks on the four serial lines between both ends.
// Assumes: Host makes the link clock from clk, four clks a half period.
// Notes: All checks sample on the system clock.
`timescale 1ns/1ps
module ssp_link_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout
);
  logic sclk_q;
  logic [9:0] rise_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Rising link edges in the current frame, cleared while deselected
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      rise_cnt <= 10'h000;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rise_cnt <= 10'h000;
      end else if (sclk && !sclk_q) begin
        rise_cnt <= rise_cnt + 10'h001;
      end
    end
  end

  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock high outside a frame");
  cs_lead_a: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("link clock rose too soon after select");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase not four clks");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("link clock low phase too short");
  cs_tail_a: assert property ($rose(cs_n) |-> !$past(sclk, 3))
    else $error("select released too close to a clock edge");
  din_hold_a: assert property (sclk && $past(sclk) |-> $stable(din))
    else $error("data in moved while link clock high");
  // Reply bits may only move with a rising link edge
  dout_launch_a: assert property (!cs_n && !$past(cs_n)
    && $changed(dout) |-> $rose(sclk))
    else $error("data out moved off a rising edge");
  word_len_a: assert property ($rose(cs_n)
    |-> rise_cnt[3:0] == 4'h0 && rise_cnt != 10'h000)
    else $error("frame not a whole number of words");
endmodule : ssp_link_props

// [test_sensor_spi_slave_port.sv]
// Purpose: Self-checking bench joining master end and sensor end.
// Assumes: One 20 MHz clock for both ends; the host makes the link clock.
// Notes: A second sensor end is driven by hand to cut a word short.
`timescale 1ns/1ps
module test_sensor_spi_slave_port;
  import ssp_pkg::*;
  logic clk, reset_n, cmd_valid, cmd_ready, cmd_last, rsp_valid;
  logic [WORD_W-1:0] cmd_word, rsp_word, usr_wdata, din_sh, dout_sh;
  logic usr_wr_en, wr_evt, rd_evt, wr2_evt, frame_on;
  logic [ADDR_W-1:0] usr_addr, wr_evt_addr, rd_evt_addr, wr2_addr, rd_seen;
  logic [BYTE_W-1:0] wr_evt_data, wr2_data;
  logic [14:0] wr_seen, wr2_seen;
  int err_total, comparisons, wr_cnt, rd_cnt, wr2_cnt;

  ssp_link_if link();
  ssp_link_if link2();
  ssp_host_end i_ssp_host_end (.clk(clk), .reset_n(reset_n),
    .link(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_word(cmd_word), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
    .rsp_word(rsp_word));
  ssp_dev_end i_ssp_dev_end (.clk(clk), .reset_n(reset_n),
    .link(link.dev), .usr_wr_en(usr_wr_en), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .wr_evt(wr_evt), .wr_evt_addr(wr_evt_addr),
    .wr_evt_data(wr_evt_data), .rd_evt(rd_evt),
    .rd_evt_addr(rd_evt_addr), .frame_act(frame_on));
  // Second sensor end, fed by the bench to break the framing
  ssp_dev_end i_ssp_dev_end_b (.clk(clk), .reset_n(reset_n),
    .link(link2.dev), .usr_wr_en(1'b0), .usr_addr(ADDR_ZERO),
    .usr_wdata(WORD_ZERO), .wr_evt(wr2_evt), .wr_evt_addr(wr2_addr),
    .wr_evt_data(wr2_data), .rd_evt(), .rd_evt_addr(), .frame_act());
  ssp_link_props i_ssp_link_props (.clk(clk), .reset_n(reset_n),
    .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din), .dout(link.dout));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Shadow the wire: data in on rises, data out where the host takes it
  always @(posedge link.sclk) din_sh <= {din_sh[14:0], link.din};
  always @(negedge link.sclk) dout_sh <= {dout_sh[14:0], link.dout};

  // Count sensor events and keep the latest of each
  always @(posedge clk) begin
    if (wr_evt === 1'b1) begin
      wr_cnt++;
      wr_seen <= {wr_evt_addr, wr_evt_data};
    end
    if (rd_evt === 1'b1) begin
      rd_cnt++;
      rd_seen <= rd_evt_addr;
    end
    if (wr2_evt === 1'b1) begin
      wr2_cnt++;
      wr2_seen <= {wr2_addr, wr2_data};
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test();
    $display("Checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task usr_write(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    usr_wr_en <= 1'b1;
    usr_addr <= a;
    usr_wdata <= d;
    @(posedge clk);
    usr_wr_en <= 1'b0;
  endtask : usr_write

  // One word through the host; request held until it is taken
  task word(input logic [15:0] w, input logic last, input logic [15:0] exp);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    cmd_last <= last;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1);
    chk(rsp_word, exp);
    chk(dout_sh, exp);
    chk(din_sh, w);
    chk({15'h0000, frame_on}, 16'h0001);
  endtask : word

  // Hand-made frame of nbits bits, 2.5 Mbps, data moved on falls
  task bang(input logic [15:0] w, input int nbits);
    @(posedge clk);
    link2.cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      link2.din <= w[15-i];
      repeat (4) @(posedge clk);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      link2.sclk <= 1'b0;
    end
    link2.din <= ~link2.din; // Stale level must not look held
    repeat (4) @(posedge clk);
    link2.cs_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : bang

  // Hangs are cut after far more than the thousand or so clks needed
  initial begin
    #1_000_000;
    err_total++;
    $display("Error at %0t ns: watchdog expired", $time);
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = WORD_ZERO;
    cmd_last = 1'b0;
    usr_wr_en = 1'b0;
    usr_addr = ADDR_ZERO;
    usr_wdata = WORD_ZERO;
    link2.sclk = 1'b0;
    link2.cs_n = 1'b1;
    link2.din = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    usr_write(7'h10, 16'ha5c3);
    usr_write(7'h23, 16'h3c00); // Odd address lands on word 0x22
    word({1'b0, 7'h10, 8'h99}, 1'b0, 16'h0000);
    word({1'b0, 7'h11, 8'h00}, 1'b0, 16'ha5c3);
    word({1'b1, 7'h22, 8'h5a}, 1'b1, 16'ha5c3);
    repeat (10) @(posedge clk);
    chk({15'h0000, frame_on}, 16'h0000);
    chk(16'(rd_cnt), 16'h0002);
    chk({9'h000, rd_seen}, 16'h0011);
    chk(16'(wr_cnt), 16'h0001);
    chk({1'b0, wr_seen}, {1'b0, 7'h22, 8'h5a});
    word({1'b0, 7'h23, 8'h00}, 1'b1, 16'h0000);
    word({1'b1, 7'h30, 8'h01}, 1'b1, 16'h3c5a);
    bang({1'b1, 7'h10, 8'hff}, 9);
    bang({1'b1, 7'h10, 8'h77}, 16);
    chk(16'(wr2_cnt), 16'h0001);
    chk({1'b0, wr2_seen}, {1'b0, 7'h10, 8'h77});
    stop_test();
  end
endmodule : test_sensor_spi_slave_port
